// *** i2c_flow_checker_assertions.sv ***
// Purpose: port-level assertions for the I2C master flow and status block
// Assumes: single aclk domain, synchronous active-low reset
// Notes: software-side state is rebuilt from the AXI4-Lite handshakes
`timescale 1ns/1ps
`include "i2c_flow_consts.vh"
module i2c_flow_checker (
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire scl_oe,
   input wire sda_oe,
   input wire irq
);
   reg [3:0] aw_a_r;
   reg [3:0] ar_a_r;
   reg [7:0] ctrl_r;
   reg start_seen_r;
   reg data_seen_r;
   reg nack_seen_r;
   wire [3:0] wr_a = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_a_r;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire ctrl_wr = w_hs && wr_a == `ADDR_CTRL;
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire st_rd = s_axi_rvalid && ar_a_r == `ADDR_STATUS;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Mirror of what software has written and last seen
   always @(posedge aclk) begin
      if (!aresetn) begin
         {aw_a_r, ar_a_r, ctrl_r, start_seen_r, data_seen_r, nack_seen_r} <= 19'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_a_r <= s_axi_awaddr;
         if (ar_hs) ar_a_r <= s_axi_araddr;
         if (w_hs && wr_a == `ADDR_DATA) data_seen_r <= 1'b1;
         if (ctrl_wr) ctrl_r <= s_axi_wdata[7:0];
         if (ctrl_wr && s_axi_wdata[`CT_START]) start_seen_r <= 1'b1;
         if (st_rd && s_axi_rready) nack_seen_r <= s_axi_rdata[`ST_NACK];
         else if (ctrl_wr && (s_axi_wdata[`CT_START] || s_axi_wdata[`CT_STOP])) nack_seen_r <= 1'b0;
      end
   end
   a_write_resp: assert property (s_axi_bvalid |-> s_axi_bresp == ((aw_a_r == `ADDR_STATUS) ? 2'b10 : 2'b00))
      else $error("write response code wrong");
   a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_read_order: assert property ($rose(s_axi_rvalid) |-> $past(ar_hs))
      else $error("read data not one cycle after request");
   a_irq_masked: assert property ((ctrl_r[6:4] == 3'h0) [*3] |-> !irq)
      else $error("interrupt with all sources disabled");
   a_phase_excl: assert property (st_rd |-> !(s_axi_rdata[`ST_ADDR] && s_axi_rdata[`ST_DATA]))
      else $error("address and data phase both set");
   a_ack_cleared: assert property (st_rd && !ctrl_r[`CT_EN] |-> !s_axi_rdata[`ST_ACK])
      else $error("ack bit set while disabled");
   a_nack_sticky: assert property (st_rd && nack_seen_r |-> s_axi_rdata[`ST_NACK])
      else $error("nack bit cleared without start or stop");
   a_start_gate: assert property (!(start_seen_r && data_seen_r) |-> !scl_oe && !sda_oe)
      else $error("bus driven before start and data");
endmodule // i2c_flow_checker
bind i2c_master_flow_status i2c_flow_checker i_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_oe(scl_oe), .sda_oe(sda_oe), .irq(irq));

// *** i2c_flow_consts.vh ***
// Purpose: constants of the I2C master flow and status block
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes: definitions only
`ifndef I2C_FLOW_CONSTS_VH
`define I2C_FLOW_CONSTS_VH
// Register byte addresses
`define ADDR_DATA 4'h0
`define ADDR_CTRL 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_IRQ_STAT 4'hc
// Status bit positions
`define ST_ACK 5
`define ST_TENB 4
`define ST_RD 3
`define ST_ADDR 2
`define ST_DATA 1
`define ST_NACK 0
// Control bit positions
`define CT_EN 0
`define CT_START 1
`define CT_STOP 2
`define CT_FLUSH 3
`define CT_TXIE 4
`define CT_RXIE 5
`define CT_NACKIE 6
// Reset values
`define CTRL_RST 8'h00
`define STATUS_RST 8'h00
// Phase length of the bit clock in cycles, three phases per bit (SCL about 66 kHz at 25 MHz)
`define HALF_BIT 8'd125
// Ten-bit address prefix
`define TEN_BIT_PREFIX 5'h1e
`endif

// *** i2c_master_flow_status.v ***
// Purpose: I2C master byte flow, pause before acknowledge, NACK handling, status flags
// Assumes: AXI4-Lite slave, 25 MHz aclk, open-drain SCL and SDA as in/out/oe triples
// Notes: read and write transfers in this block; received data latched to the data read port
// Summary of operation
// - On a write the master holds at the start of the acknowledge cycle while the transmit buffer is empty.
// - A late next byte makes the acknowledge clock of the previous byte go out just before its data clocks.
// - With start or stop requested the master never holds before the acknowledge cycle.
// - A NACK on address or data of a write sets the NACK flag and stalls until start or stop is requested.
// - Transmit empty, receive full and NACK flags each can raise the interrupt.
// - Status bit 5 reads 1 when the last byte was acknowledged.
// - The acknowledge bit clears with enable low or on a NACK and survives starts and reads.
// - While held before an acknowledge the acknowledge bit waits for the next byte and that acknowledge.
// - Status bit 4 sets after start with address prefix 11110 and clears after the first address byte.
// - Status bit 3 is the read direction taken from the transmit buffer lsb at start.
// - Status bit 2 is high while the address byte shifts out.
// - Status bit 1 is high while a data byte shifts.
// - Status bit 0 rises on a NACK received with neither start nor stop active.
// - The NACK flag clears only when software sets start or stop.
// - No start condition goes out until start is requested and a byte is loaded.
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "i2c_flow_consts.vh"
module i2c_master_flow_status (
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   output reg irq
);
   // Sequencer states
   localparam S_IDLE = 3'd0;
   localparam S_START = 3'd1;
   localparam S_BITS = 3'd2;
   localparam S_HOLD = 3'd3;
   localparam S_ACK = 3'd4;
   localparam S_NSTALL = 3'd5;
   localparam S_STOP = 3'd6;

   // Register decode used by read and write paths
   function is_reg;
      input [3:0] a;
      begin
         is_reg = (a == `ADDR_DATA) || (a == `ADDR_CTRL) || (a == `ADDR_STATUS) || (a == `ADDR_IRQ_STAT);
      end
   endfunction

   wire sda_s;
   wire scl_s;
   reg [7:0] ctrl_r;
   reg [7:0] txbuf_r;
   reg [7:0] rxbuf_r;
   reg [7:0] shift_r;
   reg tx_empty_r;
   reg rx_full_r;
   reg ack_r;
   reg tenb_r;
   reg rd_r;
   reg addr_ph_r;
   reg data_ph_r;
   reg nack_r;
   reg first_r;
   reg [2:0] state_r;
   reg [3:0] bit_r;
   reg [7:0] tick_r;
   reg [1:0] phase_r;
   reg aw_hold_r;
   reg w_hold_r;
   reg [3:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;

   i2c_sync2 u_sync_sda (.aclk(aclk), .aresetn(aresetn), .din(sda_in), .dout(sda_s));
   i2c_sync2 u_sync_scl (.aclk(aclk), .aresetn(aresetn), .din(scl_in), .dout(scl_s));

   wire en = ctrl_r[`CT_EN];
   wire start_req = ctrl_r[`CT_START];
   wire stop_req = ctrl_r[`CT_STOP];
   wire tick = (tick_r == `HALF_BIT);
   wire do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
   wire wr_ctrl = do_write && awaddr_r == `ADDR_CTRL && wstrb_r[0];
   wire wr_data = do_write && awaddr_r == `ADDR_DATA && wstrb_r[0];
   wire wr_irq = do_write && awaddr_r == `ADDR_IRQ_STAT && wstrb_r[0];
   wire [7:0] status = {2'b00, ack_r, tenb_r, rd_r, addr_ph_r, data_ph_r, nack_r};
   wire [2:0] irq_src = {nack_r, rx_full_r, tx_empty_r};
   wire [2:0] irq_en = {ctrl_r[`CT_NACKIE], ctrl_r[`CT_RXIE], ctrl_r[`CT_TXIE]};
   wire ack_seen = !sda_s;

   // AXI write channel capture, address and data in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[3:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (is_reg(awaddr_r) && awaddr_r != `ADDR_STATUS) ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read channel, one read at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_reg({s_axi_araddr[3:2], 2'b00}) ? 2'b00 : 2'b10;
            case ({s_axi_araddr[3:2], 2'b00})
               `ADDR_DATA: s_axi_rdata <= {24'h000000, rxbuf_r};
               `ADDR_CTRL: s_axi_rdata <= {24'h000000, ctrl_r};
               `ADDR_STATUS: s_axi_rdata <= {24'h000000, status}; // Reads leave ack untouched
               `ADDR_IRQ_STAT: s_axi_rdata <= {29'h00000000, irq_src};
               default: s_axi_rdata <= 32'h00000000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Interrupt output, level from enabled flags
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_src & irq_en);
      end
   end

   // Bit timing divider, paused while a released clock still reads low
   always @(posedge aclk) begin
      if (!aresetn || state_r == S_IDLE || state_r == S_HOLD || state_r == S_NSTALL || tick ||
          (phase_r == 2'b10 && !scl_s)) begin
         tick_r <= 8'h00;
      end else begin
         tick_r <= tick_r + 8'h01;
      end
   end

   // Transaction sequencer, control and status
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `CTRL_RST;
         txbuf_r <= 8'h00;
         rxbuf_r <= 8'h00;
         shift_r <= 8'h00;
         tx_empty_r <= 1'b1;
         rx_full_r <= 1'b0;
         ack_r <= 1'b0;
         tenb_r <= 1'b0;
         rd_r <= 1'b0;
         addr_ph_r <= 1'b0;
         data_ph_r <= 1'b0;
         nack_r <= 1'b0;
         first_r <= 1'b0;
         state_r <= S_IDLE;
         bit_r <= 4'h0;
         phase_r <= 2'b00;
         scl_out <= 1'b0;
         scl_oe <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= wdata_r[7:0] & 8'hf7;
            if (wdata_r[`CT_START] || wdata_r[`CT_STOP]) begin
               nack_r <= 1'b0; // Only start or stop clears it
            end
            if (wdata_r[`CT_FLUSH]) begin
               tx_empty_r <= 1'b1; // Discard stale byte
            end
         end
         if (wr_data) begin
            txbuf_r <= wdata_r[7:0];
            tx_empty_r <= 1'b0;
         end
         if (wr_irq && wdata_r[1]) begin
            rx_full_r <= 1'b0;
         end
         if (!en) begin
            ack_r <= 1'b0;
            state_r <= S_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            addr_ph_r <= 1'b0;
            data_ph_r <= 1'b0;
         end else begin
            case (state_r)
               S_IDLE: begin
                  scl_oe <= 1'b0;
                  sda_oe <= 1'b0;
                  if (start_req && !tx_empty_r && !wr_data && !(wr_ctrl && wdata_r[`CT_FLUSH])) begin
                     shift_r <= txbuf_r;
                     tx_empty_r <= 1'b1;
                     rd_r <= txbuf_r[0];
                     tenb_r <= (txbuf_r[7:3] == `TEN_BIT_PREFIX);
                     ctrl_r[`CT_START] <= 1'b0;
                     first_r <= 1'b1;
                     sda_oe <= 1'b1; // Data low while clock high
                     state_r <= S_START;
                  end else if (stop_req) begin
                     ctrl_r[`CT_STOP] <= 1'b0;
                  end
               end
               S_START: begin
                  if (tick) begin
                     scl_oe <= 1'b1;
                     addr_ph_r <= 1'b1;
                     bit_r <= 4'h0;
                     phase_r <= 2'b00;
                     state_r <= S_BITS;
                  end
               end
               S_BITS: begin
                  if (tick) begin
                     phase_r <= phase_r + 2'b01;
                     if (phase_r == 2'b00) begin
                        // Present bit while clock low
                        sda_oe <= (rd_r && !addr_ph_r) ? 1'b0 : !shift_r[7];
                     end else if (phase_r == 2'b01) begin
                        scl_oe <= 1'b0;
                     end else begin
                        scl_oe <= 1'b1;
                        phase_r <= 2'b00;
                        shift_r <= {shift_r[6:0], sda_s};
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'h7) begin
                           addr_ph_r <= 1'b0;
                           data_ph_r <= 1'b0;
                           if (first_r) begin
                              tenb_r <= 1'b0;
                           end
                           // Write pauses ahead of acknowledge unless start or stop pending
                           if (!rd_r && tx_empty_r && !start_req && !stop_req) begin
                              state_r <= S_HOLD;
                           end else begin
                              state_r <= S_ACK;
                           end
                        end
                     end
                  end
               end
               S_HOLD: begin
                  scl_oe <= 1'b1;
                  if (!tx_empty_r || start_req || stop_req) begin
                     state_r <= S_ACK; // Acknowledge clock leads next byte
                  end
               end
               S_ACK: begin
                  if (tick) begin
                     phase_r <= phase_r + 2'b01;
                     if (phase_r == 2'b00) begin
                        sda_oe <= (rd_r && !first_r) ? !(stop_req || start_req) : 1'b0;
                     end else if (phase_r == 2'b01) begin
                        scl_oe <= 1'b0;
                     end else begin
                        scl_oe <= 1'b1;
                        phase_r <= 2'b00;
                        bit_r <= 4'h0;
                        first_r <= 1'b0;
                        if (rd_r && !first_r) begin
                           rxbuf_r <= shift_r;
                           rx_full_r <= 1'b1;
                        end
                        ack_r <= (rd_r && !first_r) ? !(stop_req || start_req) : ack_seen;
                        if (!ack_seen && !(rd_r && !first_r) && !start_req && !stop_req) begin
                           nack_r <= 1'b1;
                           state_r <= S_NSTALL;
                        end else if ((rd_r && !first_r) && (start_req || stop_req)) begin
                           nack_r <= !start_req && !stop_req;
                           state_r <= S_STOP;
                        end else if (start_req || stop_req) begin
                           state_r <= S_STOP;
                        end else if (rd_r) begin
                           data_ph_r <= 1'b1;
                           state_r <= S_BITS;
                        end else begin
                           shift_r <= txbuf_r;
                           tx_empty_r <= 1'b1;
                           data_ph_r <= 1'b1;
                           state_r <= S_BITS;
                        end
                     end
                  end
               end
               S_NSTALL: begin
                  scl_oe <= 1'b1;
                  if (start_req || stop_req) begin
                     state_r <= S_STOP;
                  end
               end
               S_STOP: begin
                  if (tick) begin
                     phase_r <= phase_r + 2'b01;
                     if (phase_r == 2'b00) begin
                        sda_oe <= !start_req; // Restart leaves data high for the next start
                     end else if (phase_r == 2'b01) begin
                        scl_oe <= 1'b0;
                     end else begin
                        phase_r <= 2'b00;
                        sda_oe <= 1'b0; // Data rises with clock high, or stays high before a restart
                        ctrl_r[`CT_STOP] <= 1'b0;
                        state_r <= S_IDLE;
                     end
                  end
               end
               default: state_r <= S_IDLE;
            endcase
         end
      end
   end
endmodule // i2c_master_flow_status

// *** i2c_slave_model.sv ***
// Purpose: behavioural I2C slave on open-drain lines
// Assumes: lines pulled up outside, no clock stretching
// Notes: acks address always; data acks unless told to refuse; read data left to pull-up
`timescale 1ns/1ps
module i2c_slave_model (
   input wire scl,
   input wire sda,
   input wire nack_data,
   output reg sda_pull
);
   reg [3:0] bit_cnt;
   reg [7:0] shift;
   reg first;
   reg rd;
   initial begin
      sda_pull = 1'b0;
      bit_cnt = 4'h0;
      shift = 8'h00;
      first = 1'b0;
      rd = 1'b0;
   end
   // Start or repeated start restarts byte framing
   always @(negedge sda) if (scl) begin
      bit_cnt = 4'h0;
      first = 1'b1;
   end
   // Shift on rising clock; ninth clock closes the byte
   always @(posedge scl) begin
      if (bit_cnt == 4'h8) begin
         if (first) rd = shift[0];
         first = 1'b0;
         bit_cnt = 4'h0;
      end else begin
         shift = {shift[6:0], sda};
         bit_cnt = bit_cnt + 4'h1;
      end
   end
   // Acknowledge slot after eight bits, line released otherwise
   always @(negedge scl) sda_pull <= (bit_cnt == 4'h8) && (first || (!rd && !nack_data));
endmodule // i2c_slave_model

// *** i2c_sync2.v ***
// Purpose: two flip-flop synchroniser for a pin input
// Assumes: aclk domain, synchronous active-low reset
// Notes: first stage read only by the second
`timescale 1ns/1ps
module i2c_sync2 (
   input wire aclk,
   input wire aresetn,
   input wire din,
   output reg dout
);
   reg meta_r;
   // Two stages, idle high like the bus
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= 1'b1;
         dout <= 1'b1;
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule // i2c_sync2

// *** tb.sv ***
// Purpose: self-checking bench of the I2C master flow and status block
// Assumes: one slave model, pull-ups on both lines
// Notes: status is observed by polling over AXI4-Lite
`timescale 1ns/1ps
`include "i2c_flow_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [3:0] aw_a = 4'h0;
   reg [3:0] ar_a = 4'h0;
   reg [31:0] w_d = 32'h0;
   reg aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, nack_data = 1'b1;
   wire aw_rdy, w_rdy, b_v, ar_rdy, r_v, scl_oe, sda_oe, sda_pull, irq;
   wire [1:0] b_resp, r_resp;
   wire [31:0] r_d;
   wire scl_w = ~scl_oe;
   wire sda_w = ~(sda_oe | sda_pull);
   logic [31:0] st;
   int bad_count = 0;
   int n_compared = 0;
   i2c_master_flow_status i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
      .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
      .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
      .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .irq(irq));
   i2c_slave_model i_slave (.scl(scl_w), .sda(sda_w), .nack_data(nack_data), .sda_pull(sda_pull));
   // Register write, address and data offered together
   task automatic wr(input [3:0] a, input [7:0] d, input [1:0] er);
      bit aw, w;
      begin
         aw = 0;
         w = 0;
         aw_a <= a;
         w_d <= {24'h0, d};
         aw_v <= 1'b1;
         w_v <= 1'b1;
         b_r <= 1'b1;
         while (!(aw && w)) begin
            @(posedge aclk);
            if (aw_v && aw_rdy) begin aw = 1; aw_v <= 1'b0; end
            if (w_v && w_rdy) begin w = 1; w_v <= 1'b0; end
         end
         do @(posedge aclk); while (!b_v);
         b_r <= 1'b0;
         `CHK(b_resp, er)
         @(posedge aclk); // Keeps bready low for one edge before the next call
      end
   endtask
   // Register read into st
   task automatic rd(input [3:0] a);
      begin
         ar_a <= a;
         ar_v <= 1'b1;
         r_r <= 1'b1;
         do @(posedge aclk); while (!ar_rdy);
         ar_v <= 1'b0;
         do @(posedge aclk); while (!r_v);
         st = r_d;
         r_r <= 1'b0;
         `CHK(r_resp, 2'b00)
         @(posedge aclk); // Keeps rready low for one edge before the next call
      end
   endtask
   // Poll one bit of a register until it reaches a value
   task automatic poll(input [3:0] a, input int b, input bit v);
      int k;
      begin
         k = 0;
         do begin rd(a); k++; end while (st[b] !== v && k < 4000);
         `CHK(st[b], v)
      end
   endtask
   task automatic end_sim;
      begin
         if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial forever #20 aclk = ~aclk;
   // Watchdog against a hung handshake or bus
   initial begin
      repeat (95000) @(posedge aclk);
      bad_count++;
      end_sim;
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`ADDR_STATUS); `CHK(st, 32'h0)
      rd(`ADDR_IRQ_STAT); `CHK(st, 32'h1)
      wr(`ADDR_STATUS, 8'hff, 2'b10);
      wr(`ADDR_CTRL, 8'h53, 2'b00);
      repeat (1000) @(posedge aclk);
      `CHK({scl_oe, sda_oe}, 2'b00)
      `CHK(irq, 1'b1)
      wr(`ADDR_DATA, 8'ha0, 2'b00);
      poll(`ADDR_STATUS, `ST_ADDR, 1'b1);
      `CHK(st[`ST_RD], 1'b0)
      poll(`ADDR_IRQ_STAT, 0, 1'b1); `CHK(irq, 1'b1)
      wr(`ADDR_DATA, 8'h3c, 2'b00);
      poll(`ADDR_STATUS, `ST_DATA, 1'b1);
      poll(`ADDR_IRQ_STAT, 0, 1'b1);
      // Software late: next byte withheld past the byte time
      repeat (6000) @(posedge aclk);
      `CHK(scl_oe, 1'b1)
      rd(`ADDR_STATUS); `CHK(st[`ST_ACK], 1'b1)
      `CHK(st[`ST_NACK], 1'b0)
      wr(`ADDR_DATA, 8'h77, 2'b00);
      poll(`ADDR_STATUS, `ST_NACK, 1'b1);
      `CHK(st[`ST_ACK], 1'b0)
      `CHK(irq, 1'b1)
      repeat (2000) @(posedge aclk);
      `CHK(scl_oe, 1'b1)
      rd(`ADDR_STATUS); `CHK(st[`ST_NACK], 1'b1)
      wr(`ADDR_CTRL, 8'h4d, 2'b00);
      poll(`ADDR_STATUS, `ST_NACK, 1'b0);
      rd(`ADDR_IRQ_STAT); `CHK(st[2:0], 3'b001)
      `CHK(irq, 1'b0)
      // Ten-bit prefix with read direction
      nack_data <= 1'b0;
      repeat (3000) @(posedge aclk);
      wr(`ADDR_DATA, 8'hf1, 2'b00);
      wr(`ADDR_CTRL, 8'h03, 2'b00);
      poll(`ADDR_STATUS, `ST_TENB, 1'b1);
      `CHK(st[`ST_RD], 1'b1)
      poll(`ADDR_STATUS, `ST_TENB, 1'b0);
      poll(`ADDR_STATUS, `ST_ACK, 1'b1);
      wr(`ADDR_CTRL, 8'h05, 2'b00);
      poll(`ADDR_CTRL, `CT_STOP, 1'b0);
      rd(`ADDR_STATUS); `CHK(st[`ST_NACK], 1'b0)
      `CHK(st[`ST_ACK], 1'b0)
      rd(`ADDR_DATA); `CHK(st, 32'hff)
      rd(`ADDR_IRQ_STAT); `CHK(st[2:0], 3'b011)
      wr(`ADDR_IRQ_STAT, 8'h02, 2'b00);
      rd(`ADDR_IRQ_STAT); `CHK(st[2:0], 3'b001)
      // Address-only write with stop already requested: no pause before acknowledge
      wr(`ADDR_DATA, 8'h42, 2'b00);
      wr(`ADDR_CTRL, 8'h07, 2'b00);
      poll(`ADDR_CTRL, `CT_STOP, 1'b0);
      `CHK(scl_oe, 1'b0)
      rd(`ADDR_STATUS); `CHK(st[`ST_ACK], 1'b1)
      wr(`ADDR_CTRL, 8'h00, 2'b00);
      rd(`ADDR_STATUS); `CHK(st[`ST_ACK], 1'b0)
      end_sim;
   end
endmodule // tb
